// *** pmsc_pkg.sv ***
// Shared constants and types for the periodic memory parity scan block.
// Assumes a single 200 MHz clock domain and a classic Wishbone register bus.
package pmsc_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned SCAN_INTERVAL_S = 3;
    localparam longint unsigned SCAN_INTERVAL_CYC_L = longint'(SCAN_INTERVAL_S) * longint'(CLK_HZ);
    localparam int unsigned SCAN_INTERVAL_CYC = 32'(SCAN_INTERVAL_CYC_L);
    localparam int unsigned MINOR_CLKS_DEF = 4;
    localparam logic [3:0] SLOT_LAST = 4'h9;
    localparam logic [3:0] START_SLOT = 4'h0;
    localparam int unsigned DIG_W = 7;
    localparam logic [9:0] CHAN_FIRST = 10'h000;
    localparam logic [9:0] CHAN_STEP = 10'h00A;
    localparam logic [9:0] CHAN_LAST = 10'h3DE;
    localparam logic [3:0] PC_STAGE1 = 4'h0;
    localparam logic [3:0] PC_STAGE2 = 4'h1;
    localparam logic [3:0] PC_STAGE3 = 4'h2;
    localparam logic [7:0] ORD_PRINT = 8'h50;
    localparam logic [7:0] ORD_TS_Y = 8'h59;
    localparam logic [7:0] ORD_TS_Z = 8'h5A;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_STATIC = 8'h08;
    localparam logic [7:0] ADR_CHAN = 8'h0C;
    localparam int unsigned CTL_CONT = 0;
    localparam int unsigned CTL_ONE_INSTR = 1;
    localparam int unsigned CTL_RETAIN = 2;
    localparam int unsigned CTL_START = 3;
    localparam int unsigned CTL_TS_CLR = 4;
    localparam int unsigned CTL_SPACE = 5;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [1:0] CYC_RST = 2'h0;

    typedef struct packed {
        logic [7:0] order;
        logic chk;
        logic [9:0] addr;
    } pmsc_instr_t;

    localparam pmsc_instr_t INSTR_RST = '{order: 8'h00, chk: 1'b0, addr: 10'h000};

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_S1 = 7'h02,
        ST_S2 = 7'h04,
        ST_TO = 7'h08,
        ST_S3 = 7'h10,
        ST_PTS = 7'h20,
        ST_PXF = 7'h40
    } pmsc_state_t;
endpackage

// *** pmsc_parity.sv ***
// Odd-pulse checker for one memory digit.
// Assumes the digit carries its own check pulse, so a good digit has an odd count.
`timescale 1ns/1ps
`default_nettype none
module pmsc_parity #(
    parameter int unsigned W = 7
) (
    input wire logic [W-1:0] digit_i,
    input wire logic vld_i,
    output logic bad_o
);
    logic [W:0] acc;
    assign acc[0] = 1'b0;
    for (genvar b = 0; b < W; b++) begin : g_bit
        assign acc[b+1] = acc[b] ^ digit_i[b];
    end
    assign bad_o = vld_i & ~acc[W];
endmodule // pmsc_parity
`default_nettype wire

// *** pmsc_timer.sv ***
// Minor-cycle slot counter and the scan interval timer.
// Assumes one clock; the interval only counts while enabled.
`timescale 1ns/1ps
`default_nettype none
module pmsc_timer import pmsc_pkg::*; #(
    parameter int unsigned INTERVAL = SCAN_INTERVAL_CYC,
    parameter int unsigned MINOR_CLKS = MINOR_CLKS_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    output logic [3:0] slot_o,
    output logic scan_tick_o
);
    logic [31:0] ivl_q;
    logic [15:0] sub_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sub_q <= 16'h0000;
            slot_o <= 4'h0;
        end else if (sub_q == 16'(MINOR_CLKS - 1)) begin
            sub_q <= 16'h0000;
            slot_o <= (slot_o == SLOT_LAST) ? 4'h0 : slot_o + 4'h1;
        end else begin
            sub_q <= sub_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            ivl_q <= 32'h0000_0000;
            scan_tick_o <= 1'b0;
        end else if (ivl_q == 32'(INTERVAL - 1)) begin
            ivl_q <= 32'h0000_0000;
            scan_tick_o <= 1'b1;
        end else begin
            ivl_q <= ivl_q + 32'h0000_0001;
            scan_tick_o <= 1'b0;
        end
    end
endmodule // pmsc_timer
`default_nettype wire

// *** pmsc_top.sv ***
// Periodic memory parity scan, print-path check and time-selection start logic.
// Assumes memory streams digits while mem_rd_o is high and flags each check period end.
`timescale 1ns/1ps
`default_nettype none
module pmsc_top import pmsc_pkg::*; #(
    parameter int unsigned SCAN_INTERVAL = SCAN_INTERVAL_CYC,
    parameter int unsigned MINOR_CLKS = MINOR_CLKS_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic fetch_req_i,
    input wire logic [DIG_W-1:0] mem_digit_i,
    input wire logic mem_dig_vld_i,
    input wire logic mem_done_i,
    output logic mem_rd_o,
    output logic [9:0] mem_addr_o,
    output logic [DIG_W-1:0] prn_digit_o,
    output logic prn_valid_o,
    output logic fetch_hold_o,
    output logic scan_pending_o,
    output logic parity_err_o,
    output logic stall_o,
    output logic [3:0] pc_o,
    output logic [1:0] ts_flag_o
);
    if (MINOR_CLKS < 2) begin : g_bad_minor
        $error("MINOR_CLKS must be at least 2");
    end
    if (SCAN_INTERVAL < 1) begin : g_bad_ivl
        $error("SCAN_INTERVAL must be at least 1");
    end

    pmsc_state_t state_q, state_d;
    pmsc_instr_t sr_q;
    logic [9:0] cr_q, nxt_chan, base, word_addr;
    logic [2:0] ctrl_q;
    logic [1:0] cyc_q;
    logic [3:0] slot, wdig;
    logic start_p_q, tsclr_p_q, space_p_q, fired_q, scan_tick, bad_now;
    logic req, wr, scanning_d, last_chan, chan_end;
    logic [31:0] wmask, rdat;

    pmsc_timer #(
        .INTERVAL(SCAN_INTERVAL),
        .MINOR_CLKS(MINOR_CLKS)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(ctrl_q[CTL_CONT] && !scan_pending_o && state_q == ST_IDLE),
        .slot_o(slot),
        .scan_tick_o(scan_tick)
    );

    pmsc_parity #(
        .W(DIG_W)
    ) u_parity (
        .digit_i(mem_digit_i),
        .vld_i(mem_dig_vld_i && mem_rd_o),
        .bad_o(bad_now)
    );

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    for (genvar l = 0; l < 4; l++) begin : g_lane
        assign wmask[8*l+7:8*l] = {8{wb_sel_i[l]}};
    end
    assign last_chan = (cr_q == CHAN_LAST);
    assign nxt_chan = last_chan ? CHAN_FIRST : cr_q + CHAN_STEP;
    assign chan_end = (state_q == ST_S2) && mem_done_i;
    assign wdig = 4'(sr_q.addr % CHAN_STEP);
    assign base = sr_q.addr - {6'h00, wdig};
    assign word_addr = base + {6'h00, slot};
    assign scanning_d = (state_d == ST_S1) || (state_d == ST_S2) ||
                        (state_d == ST_TO) || (state_d == ST_S3);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (scan_pending_o && fetch_req_i && !stall_o) begin
                    state_d = ST_S1;
                end else if (start_p_q && sr_q.order == ORD_PRINT) begin
                    state_d = ST_PTS;
                end
            end
            ST_S1: state_d = ST_S2;
            ST_S2: begin
                if (mem_done_i) begin
                    state_d = last_chan ? ST_S3 : ST_TO;
                end
            end
            ST_TO: begin
                if (!stall_o) begin
                    state_d = ST_S2;
                end
            end
            ST_S3: begin
                if (!stall_o) begin
                    state_d = ST_IDLE;
                end
            end
            ST_PTS: begin
                if (fired_q && ts_flag_o == 2'b11) begin
                    state_d = ST_PXF;
                end
            end
            ST_PXF: begin
                if (mem_done_i) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
            start_p_q <= 1'b0;
            tsclr_p_q <= 1'b0;
            space_p_q <= 1'b0;
        end else begin
            start_p_q <= 1'b0;
            tsclr_p_q <= 1'b0;
            space_p_q <= 1'b0;
            if (wr && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
                ctrl_q <= wb_dat_i[2:0];
                start_p_q <= wb_dat_i[CTL_START];
                tsclr_p_q <= wb_dat_i[CTL_TS_CLR];
                space_p_q <= wb_dat_i[CTL_SPACE];
            end
        end
    end

    // The scan owns the static register while it runs, so operator writes are dropped.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sr_q <= INSTR_RST;
            cr_q <= CHAN_FIRST;
        end else if (state_q == ST_S1) begin
            sr_q <= INSTR_RST;
            cr_q <= CHAN_FIRST;
        end else if (chan_end) begin
            cr_q <= nxt_chan;
            sr_q.addr <= nxt_chan;
        end else if (wr && wb_adr_i == ADR_STATIC && state_q == ST_IDLE) begin
            sr_q <= pmsc_instr_t'((wb_dat_i & wmask) | ({13'h0000, sr_q} & ~wmask));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_pending_o <= 1'b0;
        end else if (scan_tick) begin
            scan_pending_o <= 1'b1;
        end else if (state_q == ST_S3 && !stall_o) begin
            scan_pending_o <= 1'b0;
        end
    end

    // Error flag: a new bad digit wins over the resume that clears it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            parity_err_o <= 1'b0;
        end else if (bad_now) begin
            parity_err_o <= 1'b1;
        end else if (start_p_q || space_p_q) begin
            parity_err_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stall_o <= 1'b0;
        end else if (chan_end && (parity_err_o || bad_now)) begin
            stall_o <= 1'b1;
        end else if (state_q == ST_PXF && bad_now) begin
            stall_o <= 1'b1;
        end else if (state_q == ST_S3 && !stall_o && ctrl_q[CTL_ONE_INSTR]) begin
            stall_o <= 1'b1;
        end else if (start_p_q && state_q != ST_PXF) begin
            stall_o <= 1'b0;
        end else if (space_p_q && state_q == ST_PXF) begin
            stall_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fired_q <= 1'b0;
        end else if (state_q != ST_PTS) begin
            fired_q <= 1'b0;
        end else if (slot == START_SLOT) begin
            fired_q <= 1'b1;
        end
    end

    // Flag 1 is the checked comparison; flag 0 trusts the digit as it stands.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ts_flag_o <= 2'b00;
        end else if (start_p_q && state_q == ST_IDLE && !ctrl_q[CTL_CONT] &&
                     (sr_q.order == ORD_TS_Y || sr_q.order == ORD_TS_Z)) begin
            ts_flag_o <= 2'b11;
        end else if (state_q == ST_PTS && fired_q && slot == wdig) begin
            ts_flag_o[0] <= 1'b1;
            ts_flag_o[1] <= ^{sr_q.chk, wdig};
        end else if (tsclr_p_q || (state_q == ST_PXF && mem_done_i)) begin
            ts_flag_o <= 2'b00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cyc_q <= CYC_RST;
        end else if (state_q == ST_PXF && mem_done_i && !ctrl_q[CTL_RETAIN]) begin
            cyc_q <= cyc_q + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_addr_o <= CHAN_FIRST;
        end else if (state_q == ST_S1) begin
            mem_addr_o <= CHAN_FIRST;
        end else if (chan_end) begin
            mem_addr_o <= nxt_chan;
        end else if (state_q == ST_PTS && state_d != ST_PXF) begin
            mem_addr_o <= word_addr;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_rd_o <= 1'b0;
            fetch_hold_o <= 1'b0;
            pc_o <= PC_STAGE1;
        end else begin
            mem_rd_o <= (state_d == ST_S2) || (state_d == ST_PXF &&
                        !(state_q == ST_PXF && bad_now) &&
                        !(stall_o && !space_p_q));
            fetch_hold_o <= scanning_d;
            pc_o <= (state_d == ST_S2 || state_d == ST_TO) ? PC_STAGE2 :
                    (state_d == ST_S3) ? PC_STAGE3 : PC_STAGE1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prn_digit_o <= '0;
            prn_valid_o <= 1'b0;
        end else begin
            prn_valid_o <= state_q == ST_PXF && mem_dig_vld_i && mem_rd_o && !bad_now;
            if (state_q == ST_PXF && mem_dig_vld_i && mem_rd_o) begin
                prn_digit_o <= mem_digit_i;
            end
        end
    end

    always_comb begin
        rdat = 32'h0000_0000;
        if (wb_adr_i == ADR_CTRL) begin
            rdat = {29'h0000_0000, ctrl_q};
        end else if (wb_adr_i == ADR_STATUS) begin
            rdat = {16'h0000, slot, fetch_hold_o, cyc_q, ts_flag_o,
                    parity_err_o, stall_o, scan_pending_o, pc_o};
        end else if (wb_adr_i == ADR_STATIC) begin
            rdat = {13'h0000, sr_q};
        end else if (wb_adr_i == ADR_CHAN) begin
            rdat = {22'h00_0000, cr_q};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= rdat;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_chan_fail;
        chan_end && (parity_err_o || bad_now);
    endsequence

    sequence s_chan_ok_mid;
        chan_end && !last_chan;
    endsequence

    a_scan_interval: assert property (scan_tick |=> scan_pending_o)
        else $error("pending not set after interval");
    a_fetch_held: assert property ((state_q inside {ST_S2, ST_TO, ST_S3}) |-> fetch_hold_o)
        else $error("fetch not held during scan");
    a_stage_one: assert property (state_q == ST_S1 |=>
        cr_q == CHAN_FIRST && sr_q.addr == CHAN_FIRST && pc_o == PC_STAGE2)
        else $error("stage one did not load channel zero");
    a_chan_step: assert property (s_chan_ok_mid |=> cr_q == $past(cr_q) + CHAN_STEP
        && state_q == ST_TO)
        else $error("channel not advanced by ten");
    a_last_chan: assert property (chan_end && last_chan |=>
        state_q == ST_S3 && pc_o == PC_STAGE3)
        else $error("last channel did not reach stage three");
    a_pend_clear: assert property (state_q == ST_S3 && !stall_o && !scan_tick
        |=> !scan_pending_o ##1 state_q == ST_IDLE || state_q == ST_S1)
        else $error("pending not cleared after stage three");
    a_err_stall: assert property (s_chan_fail |=> stall_o && parity_err_o
        && (state_q inside {ST_TO, ST_S3}))
        else $error("no stall after channel error");
    a_stall_addr: assert property (s_chan_fail and s_chan_ok_mid |=>
        sr_q.addr == $past(cr_q) + CHAN_STEP)
        else $error("stalled address not ten greater");
    a_last_err: assert property (s_chan_fail ##0 last_chan |=> stall_o
        && pc_o == PC_STAGE3 && sr_q.addr == CHAN_FIRST)
        else $error("last channel error display wrong");
    a_retain_hold: assert property (ctrl_q[CTL_RETAIN] && state_q == ST_PXF
        && mem_done_i |=> $stable(cyc_q))
        else $error("cycle counter advanced while retained");
    a_print_stall: assert property (state_q == ST_PXF && bad_now |=>
        stall_o && parity_err_o && !mem_rd_o && !prn_valid_o)
        else $error("printer path did not stall on bad digit");
    a_ts_both: assert property ($rose(state_q == ST_PXF) |->
        $past(ts_flag_o) == 2'b11 && $past(fired_q))
        else $error("transfer began without both flags");
endmodule // pmsc_top
`default_nettype wire

// *** pmsc_mem_model.sv ***
// Behavioural model of the main memory channels seen by the parity scan block.
// Assumes the block takes a digit in every cycle in which read and valid are both high.
`timescale 1ns/1ps
`default_nettype none
module pmsc_mem_model import pmsc_pkg::*; #(
    parameter int unsigned DIGITS = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mem_rd_i,
    input wire logic [9:0] mem_addr_i,
    input wire logic [9:0] bad_addr_i,
    output logic [DIG_W-1:0] digit_o,
    output logic dig_vld_o,
    output logic done_o
);
    logic [3:0] cnt_q;
    logic [DIG_W-1:0] last_q;
    logic [DIG_W-1:0] good;
    // Each good digit carries a single pulse; the injected bad one carries two.
    assign good = DIG_W'(1) << cnt_q[1:0];
    assign dig_vld_o = mem_rd_i && (cnt_q < 4'(DIGITS));
    // A released data line shows the inverse of its last digit, never a stale copy.
    assign digit_o = !dig_vld_o ? ~last_q :
        ((mem_addr_i == bad_addr_i) && (cnt_q == 4'h1)) ? 7'h03 : good;
    assign done_o = mem_rd_i && (cnt_q == 4'(DIGITS));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
            last_q <= '0;
        end else if (done_o) begin
            cnt_q <= 4'h0;
        end else if (dig_vld_o) begin
            cnt_q <= cnt_q + 4'h1;
            last_q <= digit_o;
        end
    end
endmodule // pmsc_mem_model
`default_nettype wire

// *** periodic_memory_parity_scan_test.sv ***
// Self-checking bench for the periodic memory parity scan block.
// Assumes pmsc_top and the memory model; the bench plays the operator console.
`timescale 1ns/1ps
`default_nettype none
module periodic_memory_parity_scan_test import pmsc_pkg::*;;
    localparam int SCAN = 200;
    typedef struct packed {
        logic [7:0] adr;
        logic [31:0] w;
        logic [31:0] e;
    } pmsc_row_t;
    pmsc_row_t rows [6] = '{'{ADR_CTRL, 32'h6, 32'h6}, '{ADR_CTRL, 32'h10, 32'h0},
        '{ADR_STATIC, 32'hFFFFFFFF, 32'h7FFFF}, '{ADR_STATIC, 32'h0, 32'h0},
        '{ADR_CHAN, 32'h123, 32'h0}, '{8'h10, 32'hFFFFFFFF, 32'h0}};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'hF;
    logic fetch_req_i = 1'b0;
    logic [9:0] bad_addr = 10'h3FF;
    logic [31:0] wb_dat_o, rd, st;
    logic wb_ack_o, mem_dig_vld_i, mem_done_i, mem_rd_o, prn_valid_o, fetch_hold_o;
    logic scan_pending_o, parity_err_o, stall_o;
    logic [DIG_W-1:0] mem_digit_i, prn_digit_o;
    logic [9:0] mem_addr_o, exp_chan;
    logic [3:0] pc_o;
    logic [1:0] ts_flag_o;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int t0, prn_cnt, chan_cnt;

    pmsc_top #(.SCAN_INTERVAL(SCAN), .MINOR_CLKS(2)) i_pmsc_top (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .fetch_req_i(fetch_req_i), .mem_digit_i(mem_digit_i), .mem_dig_vld_i(mem_dig_vld_i),
        .mem_done_i(mem_done_i), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
        .prn_digit_o(prn_digit_o), .prn_valid_o(prn_valid_o), .fetch_hold_o(fetch_hold_o),
        .scan_pending_o(scan_pending_o), .parity_err_o(parity_err_o), .stall_o(stall_o),
        .pc_o(pc_o), .ts_flag_o(ts_flag_o));
    pmsc_mem_model #(.DIGITS(3)) i_pmsc_mem_model (.clk_i(clk_i), .rst_i(rst_i),
        .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .bad_addr_i(bad_addr),
        .digit_o(mem_digit_i), .dig_vld_o(mem_dig_vld_i), .done_o(mem_done_i));

    always #2.5 clk_i = ~clk_i;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic single cycle; the request is held until ack is seen at an edge.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (fetch_hold_o === 1'b1 && mem_done_i === 1'b1) begin
            chk(32'(mem_addr_o), 32'(exp_chan));
            exp_chan <= exp_chan + CHAN_STEP;
            chan_cnt++;
        end
        if (prn_valid_o === 1'b1) begin
            prn_cnt++;
            chk(32'(^prn_digit_o), 32'h1);
        end
        if (cycles == 40000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk(32'({pc_o, ts_flag_o, scan_pending_o, stall_o, parity_err_o, mem_rd_o}), 32'h0);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(rd & 32'h0FFF, 32'h0);
        foreach (rows[i]) begin
            wb(1'b1, rows[i].adr, rows[i].w);
            wb(1'b0, rows[i].adr, 32'h0);
            chk(rd, rows[i].e);
        end
        // Scan with faults in channels 110 and 990.
        bad_addr <= 10'h06E;
        exp_chan <= CHAN_FIRST;
        chan_cnt = 0;
        t0 = cycles;
        wb(1'b1, ADR_CTRL, 32'h1);
        @(posedge clk_i iff scan_pending_o === 1'b1);
        #1;
        chk(32'((cycles - t0) inside {[SCAN - 5:SCAN + 10]}), 32'h1);
        chk(32'({stall_o, parity_err_o, fetch_hold_o}), 32'h0);
        @(posedge clk_i);
        fetch_req_i <= 1'b1;
        @(posedge clk_i);
        fetch_req_i <= 1'b0;
        tick(1);
        chk(32'({fetch_hold_o, mem_rd_o, pc_o, mem_addr_o}), 32'hC400);
        @(posedge clk_i iff stall_o === 1'b1);
        #1;
        chk(32'({parity_err_o, scan_pending_o, mem_rd_o, pc_o}), 32'h61);
        wb(1'b0, ADR_STATIC, 32'h0);
        chk(rd & 32'h3FF, 32'h078);
        tick(10);
        chk(32'(parity_err_o), 32'h1);
        bad_addr <= 10'h3DE;
        wb(1'b1, ADR_CTRL, 32'h9);
        tick(2);
        chk(32'({stall_o, parity_err_o}), 32'h0);
        @(posedge clk_i iff stall_o === 1'b1);
        #1;
        chk(32'({parity_err_o, pc_o}), 32'h12);
        chk(32'(chan_cnt), 32'd100);
        wb(1'b0, ADR_STATIC, 32'h0);
        chk(rd & 32'h3FF, 32'h0);
        wb(1'b1, ADR_CTRL, 32'hA);
        tick(3);
        chk(32'({fetch_hold_o, scan_pending_o, stall_o, pc_o}), 32'h10);
        // Print word 405; its low digit 5 has two ones, so the check bit is set.
        bad_addr <= 10'h3FF;
        wb(1'b1, ADR_CTRL, 32'h14);
        wb(1'b0, ADR_STATUS, 32'h0);
        st = rd;
        wb(1'b1, ADR_STATIC, {13'h0, ORD_PRINT, 1'b1, 10'h195});
        prn_cnt = 0;
        wb(1'b1, ADR_CTRL, 32'hC);
        @(posedge clk_i iff mem_rd_o === 1'b1);
        #1;
        chk(32'({ts_flag_o, mem_addr_o}), 32'hD95);
        @(posedge clk_i iff mem_rd_o === 1'b0);
        tick(3);
        chk(32'(prn_cnt), 32'd3);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(rd & 32'h600, st & 32'h600);
        // Second digit of the word arrives with an even pulse count.
        bad_addr <= 10'h195;
        prn_cnt = 0;
        wb(1'b1, ADR_CTRL, 32'hC);
        @(posedge clk_i iff parity_err_o === 1'b1);
        tick(2);
        chk(32'({stall_o, mem_rd_o}), 32'h2);
        chk(32'(prn_cnt), 32'd1);
        wb(1'b1, ADR_CTRL, 32'h24);
        tick(30);
        chk(32'({mem_rd_o, prn_cnt[3:0]}), 32'h2);
        // The time-select order presets both flags, so the zero word is taken.
        // The print order then goes in without a flag clear, retain released.
        bad_addr <= 10'h3FF;
        wb(1'b1, ADR_CTRL, 32'h10);
        wb(1'b1, ADR_STATIC, {13'h0, ORD_TS_Y, 1'b1, 10'h195});
        wb(1'b1, ADR_CTRL, 32'h8);
        wb(1'b1, ADR_STATIC, {13'h0, ORD_PRINT, 1'b1, 10'h195});
        chk(32'(ts_flag_o), 32'h3);
        wb(1'b1, ADR_CTRL, 32'h8);
        @(posedge clk_i iff mem_rd_o === 1'b1);
        #1;
        chk(32'({ts_flag_o, mem_addr_o}), 32'hD90);
        tick(20);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(rd & 32'h600, (st + 32'h200) & 32'h600);
        finish_test();
    end
endmodule // periodic_memory_parity_scan_test
`default_nettype wire
